/* tic_pkg.sv */
// ==========================================================
// register map, field positions and reset values
package tic_pkg;
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam int          REG_W        = 16;
	localparam int          NSRC         = 16;
	localparam int          PRI_W        = 3;
	localparam int          ID_W         = 4;

	// ==========================================================
	// byte offsets of the registers
	localparam logic [7:0]  OFS_TRAP     = 8'h00;
	localparam logic [7:0]  OFS_FLAG0    = 8'h04;
	localparam logic [7:0]  OFS_EN0      = 8'h08;
	localparam logic [7:0]  OFS_PRI1     = 8'h0C;
	localparam logic [7:0]  OFS_PRI18    = 8'h10;
	localparam logic [7:0]  OFS_ENC2     = 8'h14;

	// ==========================================================
	// trap_control_status fields
	localparam int          NEST_DIS_BIT = 15;
	localparam int          OVA_FLAG_BIT = 14;
	localparam int          OVB_FLAG_BIT = 13;
	localparam int          CA_FLAG_BIT  = 12;
	localparam int          CB_FLAG_BIT  = 11;
	localparam int          OVA_TE_BIT   = 10;
	localparam int          OVB_TE_BIT   = 9;
	localparam int          COV_TE_BIT   = 8;

	// ==========================================================
	// flag and enable source positions
	localparam int          SRC_EXT0     = 0;
	localparam int          SRC_CAP1     = 1;
	localparam int          SRC_CMP1     = 2;
	localparam int          SRC_DMA0     = 4;
	localparam int          SRC_CAP2     = 5;
	localparam int          SRC_CMP2     = 6;
	localparam int          SRC_TMR2     = 7;
	localparam int          SRC_ENC2     = 15;
	localparam int          ENC2_FLAG    = 0;
	localparam int          ENC2_EN      = 1;

	// ==========================================================
	// priority field low bits
	localparam int          TMR2_PRI_LO  = 12;
	localparam int          CMP2_PRI_LO  = 8;
	localparam int          CAP2_PRI_LO  = 4;
	localparam int          DMA0_PRI_LO  = 0;
	localparam int          ENC2_PRI_LO  = 12;
	localparam logic [2:0]  DEF_PRI      = 3'h4;
	localparam logic [2:0]  PRI_OFF      = 3'h0;

	// ==========================================================
	// reset values and writable masks
	localparam logic [15:0] RST_ZERO     = 16'h0000;
	localparam logic [15:0] RST_PRI1     = 16'h4444;
	localparam logic [15:0] RST_PRI18    = 16'h4040;
	localparam logic [15:0] MSK_TRAP     = 16'hFFFE;
	localparam logic [15:0] MSK_FLAG0    = 16'h7FFF;
	localparam logic [15:0] MSK_EN0      = 16'h7FFF;
	localparam logic [15:0] MSK_PRI1     = 16'h7777;
	localparam logic [15:0] MSK_PRI18    = 16'h7070;
	localparam logic [15:0] MSK_ENC2     = 16'h0003;
	localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
endpackage : tic_pkg

/* tic_reg16.sv */
// ==========================================================
// one 16-bit register: software write, hardware set wins
module tic_reg16 #(
	parameter logic [15:0] RST  = 16'h0000,
	parameter logic [15:0] MASK = 16'hFFFF
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_wr,
	input  wire logic [15:0] i_wdata,
	input  wire logic [15:0] i_set,
	output logic      [15:0] o_q
);
	logic [15:0] q_r;
	logic [15:0] q_nxt;

	assign q_nxt = ((i_wr ? i_wdata : q_r) | i_set) & MASK;
	assign o_q   = q_r;

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			q_r <= RST;
		else
			q_r <= q_nxt;
	end
endmodule : tic_reg16

/* tic_trap_irq_ctrl.sv */
// Function
// - overflow flag set only by that accumulator's trap
// - catastrophic flags per accumulator, set on trap
// - overflow traps only while own enable set
// - one catastrophic enable covers both accumulators
// - request sets its flag; otherwise reads zero
// - flags: compare1 bit2, capture1 bit1, ext0 bit0
// - request forwarded only while its enable set
// - priority 7 highest, 1 lowest, 0 disables
// - timer2 priority in bits 14-12 of priority1
// - compare2 priority in bits 10-8 of priority1
//
// The APB register port and the register addresses are this design's own decisions.
module tic_trap_irq_ctrl (
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rst,
	input  wire logic                       i_psel,
	input  wire logic                       i_penable,
	input  wire logic                       i_pwrite,
	input  wire logic [tic_pkg::ADDR_W-1:0] i_paddr,
	input  wire logic [tic_pkg::DATA_W-1:0] i_pwdata,
	output logic      [tic_pkg::DATA_W-1:0] o_prdata,
	output logic                            o_pready,
	output logic                            o_pslverr,
	input  wire logic [tic_pkg::NSRC-2:0]   i_irq_req,
	input  wire logic                       i_enc2_req,
	input  wire logic                       i_acc_a_ovf,
	input  wire logic                       i_acc_b_ovf,
	input  wire logic                       i_acc_a_cat,
	input  wire logic                       i_acc_b_cat,
	input  wire logic [tic_pkg::PRI_W-1:0]  i_cpu_level,
	output logic                            o_trap,
	output logic                            o_irq_req,
	output logic      [tic_pkg::ID_W-1:0]   o_irq_id,
	output logic      [tic_pkg::PRI_W-1:0]  o_irq_level
);
	import tic_pkg::*;

	// ==========================================================
	// apb decode
	logic              setup;
	logic              wr_acc;
	logic              hit_trap;
	logic              hit_flag;
	logic              hit_en;
	logic              hit_pri1;
	logic              hit_pri18;
	logic              hit_enc2;
	logic              hit_any;
	logic [REG_W-1:0]  wdata;
	logic [REG_W-1:0]  rdata;
	logic              pready_r;
	logic [DATA_W-1:0] prdata_r;
	logic              pslverr_r;

	assign setup     = i_psel & ~i_penable;
	assign wr_acc    = i_psel & i_penable & i_pwrite & pready_r & ~pslverr_r;
	assign hit_trap  = (i_paddr == OFS_TRAP);
	assign hit_flag  = (i_paddr == OFS_FLAG0);
	assign hit_en    = (i_paddr == OFS_EN0);
	assign hit_pri1  = (i_paddr == OFS_PRI1);
	assign hit_pri18 = (i_paddr == OFS_PRI18);
	assign hit_enc2  = (i_paddr == OFS_ENC2);
	assign hit_any   = hit_trap | hit_flag | hit_en | hit_pri1 | hit_pri18 | hit_enc2;
	assign wdata     = i_pwdata[REG_W-1:0];

	// ==========================================================
	// register contents
	logic [REG_W-1:0] trap_q;
	logic [REG_W-1:0] flag_q;
	logic [REG_W-1:0] en_q;
	logic [REG_W-1:0] pri1_q;
	logic [REG_W-1:0] pri18_q;
	logic [REG_W-1:0] enc2_q;
	logic [REG_W-1:0] trap_set;
	logic [REG_W-1:0] flag_set;
	logic [REG_W-1:0] enc2_set;

	// ==========================================================
	// trap detection
	logic a_ovf_hit;
	logic b_ovf_hit;
	logic a_cat_hit;
	logic b_cat_hit;
	logic trap_fire;

	assign a_ovf_hit = i_acc_a_ovf & trap_q[OVA_TE_BIT];
	assign b_ovf_hit = i_acc_b_ovf & trap_q[OVB_TE_BIT];
	assign a_cat_hit = i_acc_a_cat & trap_q[COV_TE_BIT];
	assign b_cat_hit = i_acc_b_cat & trap_q[COV_TE_BIT];
	assign trap_fire = a_ovf_hit | b_ovf_hit | a_cat_hit | b_cat_hit;

	always_comb
	begin
		trap_set               = RST_ZERO;
		trap_set[OVA_FLAG_BIT] = a_ovf_hit;
		trap_set[OVB_FLAG_BIT] = b_ovf_hit;
		trap_set[CA_FLAG_BIT]  = a_cat_hit;
		trap_set[CB_FLAG_BIT]  = b_cat_hit;
	end

	assign flag_set = {1'b0, i_irq_req};

	always_comb
	begin
		enc2_set            = RST_ZERO;
		enc2_set[ENC2_FLAG] = i_enc2_req;
	end

	tic_reg16 #(.RST(RST_ZERO), .MASK(MSK_TRAP)) u_trap (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_wr      (wr_acc & hit_trap),
		.i_wdata   (wdata),
		.i_set     (trap_set),
		.o_q       (trap_q)
	);

	tic_reg16 #(.RST(RST_ZERO), .MASK(MSK_FLAG0)) u_flag0 (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_wr      (wr_acc & hit_flag),
		.i_wdata   (wdata),
		.i_set     (flag_set),
		.o_q       (flag_q)
	);

	tic_reg16 #(.RST(RST_ZERO), .MASK(MSK_EN0)) u_en0 (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_wr      (wr_acc & hit_en),
		.i_wdata   (wdata),
		.i_set     (RST_ZERO),
		.o_q       (en_q)
	);

	tic_reg16 #(.RST(RST_PRI1), .MASK(MSK_PRI1)) u_pri1 (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_wr      (wr_acc & hit_pri1),
		.i_wdata   (wdata),
		.i_set     (RST_ZERO),
		.o_q       (pri1_q)
	);

	tic_reg16 #(.RST(RST_PRI18), .MASK(MSK_PRI18)) u_pri18 (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_wr      (wr_acc & hit_pri18),
		.i_wdata   (wdata),
		.i_set     (RST_ZERO),
		.o_q       (pri18_q)
	);

	tic_reg16 #(.RST(RST_ZERO), .MASK(MSK_ENC2)) u_enc2 (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_wr      (wr_acc & hit_enc2),
		.i_wdata   (wdata),
		.i_set     (enc2_set),
		.o_q       (enc2_q)
	);

	// ==========================================================
	// read mux
	assign rdata = ({REG_W{hit_trap}}  & trap_q)
	             | ({REG_W{hit_flag}}  & flag_q)
	             | ({REG_W{hit_en}}    & en_q)
	             | ({REG_W{hit_pri1}}  & pri1_q)
	             | ({REG_W{hit_pri18}} & pri18_q)
	             | ({REG_W{hit_enc2}}  & enc2_q);

	// ==========================================================
	// arbitration
	logic [NSRC-1:0]  pend;
	logic [PRI_W-1:0] pri_fld [NSRC];
	logic [PRI_W-1:0] best_pri;
	logic [ID_W-1:0]  best_id;
	logic             allow;

	assign pend[NSRC-2:0] = flag_q[NSRC-2:0] & en_q[NSRC-2:0];
	assign pend[SRC_ENC2] = enc2_q[ENC2_FLAG] & enc2_q[ENC2_EN];

	always_comb
	begin
		for (int i = 0; i < NSRC; i++)
			pri_fld[i] = DEF_PRI;
		pri_fld[SRC_TMR2] = pri1_q[TMR2_PRI_LO +: PRI_W];
		pri_fld[SRC_CMP2] = pri1_q[CMP2_PRI_LO +: PRI_W];
		pri_fld[SRC_CAP2] = pri1_q[CAP2_PRI_LO +: PRI_W];
		pri_fld[SRC_DMA0] = pri1_q[DMA0_PRI_LO +: PRI_W];
		pri_fld[SRC_ENC2] = pri18_q[ENC2_PRI_LO +: PRI_W];
	end

	// lowest index wins among equal levels
	always_comb
	begin
		best_pri = PRI_OFF;
		best_id  = '0;
		for (int i = 0; i < NSRC; i++)
		begin
			if (pend[i] && (pri_fld[i] > best_pri))
			begin
				best_pri = pri_fld[i];
				best_id  = ID_W'(i);
			end
		end
	end

	assign allow = trap_q[NEST_DIS_BIT] ? (i_cpu_level == PRI_OFF)
	                                    : (best_pri > i_cpu_level);

	// ==========================================================
	// output flops
	logic             trap_r;
	logic             irq_req_r;
	logic [ID_W-1:0]  irq_id_r;
	logic [PRI_W-1:0] irq_lvl_r;

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			pready_r  <= 1'b0;
			prdata_r  <= RD_ZERO;
			pslverr_r <= 1'b0;
			trap_r    <= 1'b0;
			irq_req_r <= 1'b0;
			irq_id_r  <= '0;
			irq_lvl_r <= PRI_OFF;
		end
		else
		begin
			pready_r  <= setup;
			prdata_r  <= {{(DATA_W-REG_W){1'b0}}, rdata};
			pslverr_r <= setup & ~hit_any;
			trap_r    <= trap_fire;
			irq_req_r <= (best_pri != PRI_OFF) & allow;
			irq_id_r  <= best_id;
			irq_lvl_r <= best_pri;
		end
	end

	assign o_pready    = pready_r;
	assign o_prdata    = prdata_r;
	assign o_pslverr   = pslverr_r;
	assign o_trap      = trap_r;
	assign o_irq_req   = irq_req_r;
	assign o_irq_id    = irq_id_r;
	assign o_irq_level = irq_lvl_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	a_ova_flag_set: assert property (
		a_ovf_hit |=> trap_q[OVA_FLAG_BIT])
		else $error("acc a overflow flag not set");

	a_ova_flag_hold: assert property (
		!a_ovf_hit && !(wr_acc && hit_trap) |=> $stable(trap_q[OVA_FLAG_BIT]))
		else $error("acc a overflow flag changed without cause");

	a_cat_flag_pair: assert property (
		i_acc_b_cat && trap_q[COV_TE_BIT] |=> trap_q[CB_FLAG_BIT] && o_trap)
		else $error("acc b catastrophic trap missing");

	a_trap_gate: assert property (
		o_trap |-> $past(trap_fire))
		else $error("trap raised with no enabled cause");

	a_flag_capture: assert property (
		i_irq_req[SRC_CMP1] |=> flag_q[SRC_CMP1])
		else $error("compare1 request flag not set");

	a_flag_readback: assert property (
		setup && hit_flag |=> o_prdata[SRC_EXT0] == $past(flag_q[SRC_EXT0]))
		else $error("ext0 flag read back wrong");

	a_enable_block: assert property (
		pend == '0 |=> !o_irq_req)
		else $error("request with nothing enabled and pending");

	a_pri_fields: assert property (
		wr_acc && hit_pri1 |=> pri_fld[SRC_TMR2] == $past(wdata[14:12])
			&& pri_fld[SRC_CMP2] == $past(wdata[10:8]))
		else $error("priority1 fields not stored");

	a_enc2_field: assert property (
		wr_acc && hit_pri18 |=> pri_fld[SRC_ENC2] == $past(wdata[14:12]))
		else $error("encoder2 priority not stored");

	a_nest_block: assert property (
		trap_q[NEST_DIS_BIT] && i_cpu_level != PRI_OFF |=> !o_irq_req)
		else $error("nested request while nesting disabled");

	a_best_level: assert property (
		o_irq_req |-> o_irq_level != PRI_OFF && o_irq_level == $past(best_pri)
			&& o_irq_id == $past(best_id))
		else $error("presented request is not the best pending");

	c_trap_seen: cover property (o_trap);
	c_irq_seen: cover property (o_irq_req && o_irq_level == 3'h7);
	c_unmapped: cover property (o_pready && o_pslverr);
endmodule : tic_trap_irq_ctrl

/* tic_core_model.sv */
// ==========================================================
// core side: takes a presented request, returns on done
module tic_core_model (
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_rst,
	input  wire logic                      i_accept,
	input  wire logic                      i_done,
	input  wire logic                      i_irq_req,
	input  wire logic [tic_pkg::PRI_W-1:0] i_irq_level,
	output logic      [tic_pkg::PRI_W-1:0] o_cpu_level
);
	import tic_pkg::*;

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			o_cpu_level <= '0;
		else if (i_done)
			o_cpu_level <= '0;
		else if (i_accept && i_irq_req)
			o_cpu_level <= i_irq_level;
	end
endmodule : tic_core_model

/* testbench.sv */
// ==========================================================
// self-checking bench
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import tic_pkg::*;

	typedef struct {logic wr; logic [7:0] a; logic [15:0] d; logic [15:0] e; logic er;} tic_row_t;

	logic              clk, rst, psel, penable, pwrite, pready, pslverr, err, on;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [NSRC-2:0]   irq_req;
	logic              enc2_req, a_ovf, b_ovf, a_cat, b_cat, trap, irq_o, accept, done;
	logic [PRI_W-1:0]  cpu_level, irq_level;
	logic [ID_W-1:0]   irq_id;
	logic [15:0]       en;
	int                failures, n_compared, cycles, c, ntr;

	tic_row_t rows[9] = '{
		'{0, OFS_TRAP, 0, 16'h0000, 0}, '{0, OFS_FLAG0, 0, 16'h0000, 0},
		'{0, OFS_EN0, 0, 16'h0000, 0}, '{0, OFS_PRI1, 0, 16'h4444, 0},
		'{0, OFS_PRI18, 0, 16'h4040, 0}, '{1, OFS_PRI1, 16'hFFFF, 16'h7777, 0},
		'{1, OFS_PRI18, 16'hFFFF, 16'h7070, 0}, '{1, OFS_EN0, 16'hFFFF, 16'h7FFF, 0},
		'{1, 8'h18, 16'hFFFF, 16'h0000, 1}};
	int         fbit[4] = '{OVA_FLAG_BIT, OVB_FLAG_BIT, CA_FLAG_BIT, CB_FLAG_BIT};
	int         tbit[4] = '{OVA_TE_BIT, OVB_TE_BIT, COV_TE_BIT, COV_TE_BIT};
	logic [15:0] ap[5] = '{16'h7123, 16'h1723, 16'h0000, 16'h1111, 16'h0010};
	logic [7:0]  ax[5] = '{{1'b1, 4'd7, 3'd7}, {1'b1, 4'd6, 3'd7}, 8'h00,
		{1'b1, 4'd4, 3'd1}, {1'b1, 4'd5, 3'd1}};

	tic_trap_irq_ctrl dut_u (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_irq_req(irq_req), .i_enc2_req(enc2_req),
		.i_acc_a_ovf(a_ovf), .i_acc_b_ovf(b_ovf), .i_acc_a_cat(a_cat), .i_acc_b_cat(b_cat),
		.i_cpu_level(cpu_level), .o_trap(trap), .o_irq_req(irq_o), .o_irq_id(irq_id),
		.o_irq_level(irq_level));

	tic_core_model core_u (.i_clk_sys(clk), .i_rst(rst), .i_accept(accept), .i_done(done),
		.i_irq_req(irq_o), .i_irq_level(irq_level), .o_cpu_level(cpu_level));

	initial clk = 0;
	always #2 clk = ~clk;

	task automatic final_report();
		if (failures == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			final_report();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// ==========================================================
	// apb transfer, entered right after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask : apb

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, irq_req, enc2_req} = '0;
		{a_ovf, b_ovf, a_cat, b_cat, accept, done} = '0;
		rst = 1;
		wt(20);
		rst <= 0;
		wt(1);
		// ==========================================================
		// register table
		foreach (rows[i])
		begin
			if (rows[i].wr)
				apb(1, rows[i].a, rows[i].d);
			apb(0, rows[i].a, 0);
			chk("rdata", rd, {16'h0000, rows[i].e});
			chk("pslverr", err, rows[i].er);
		end
		// ==========================================================
		// traps, own enable off then on
		for (int i = 0; i < 8; i++)
		begin
			c = i % 4;
			on = (i >= 4);
			en = on ? (16'h0001 << tbit[c]) : (16'h0700 & ~(16'h0001 << tbit[c]));
			apb(1, OFS_TRAP, en);
			{a_ovf, b_ovf, a_cat, b_cat} <= 4'b1000 >> c;
			ntr = 0;
			repeat (5)
			begin
				@(posedge clk);
				{a_ovf, b_ovf, a_cat, b_cat} <= 4'b0000;
				ntr += trap;
			end
			chk("trap_pulses", ntr, {31'h0, on});
			apb(0, OFS_TRAP, 0);
			chk("trap_reg", rd, on ? en | (16'h0001 << fbit[c]) : en);
		end
		// ==========================================================
		// flag positions, enables off
		apb(1, OFS_TRAP, 0);
		apb(1, OFS_EN0, 0);
		for (int i = 0; i < 3; i++)
		begin
			apb(1, OFS_FLAG0, 0);
			irq_req <= 15'h0001 << i;
			wt(1);
			irq_req <= 0;
			wt(3);
			chk("irq_off", irq_o, 0);
			apb(0, OFS_FLAG0, 0);
			chk("flag0", rd, 32'h0000_0001 << i);
		end
		apb(1, OFS_EN0, 16'h0004);
		wt(2);
		chk("irq_cmp1", {irq_o, irq_id, irq_level}, {1'b1, 4'd2, DEF_PRI});
		// ==========================================================
		// arbitration among sources 4..7
		apb(1, OFS_EN0, 16'h00F0);
		apb(1, OFS_FLAG0, 16'h00F0);
		for (int i = 0; i < 5; i++)
		begin
			apb(1, OFS_PRI1, ap[i]);
			wt(2);
			chk("irq_pick", {irq_o, irq_id, irq_level}, ax[i]);
		end
		// ==========================================================
		// nesting
		apb(1, OFS_PRI1, 16'h4000);
		wt(2);
		accept <= 1;
		wt(1);
		accept <= 0;
		wt(3);
		chk("cpu_level", cpu_level, 4);
		chk("irq_same", irq_o, 0);
		apb(1, OFS_PRI1, 16'h5000);
		wt(2);
		chk("irq_nest", irq_o, 1);
		apb(1, OFS_TRAP, 16'h8000);
		wt(2);
		chk("irq_nodis", irq_o, 0);
		done <= 1;
		wt(1);
		done <= 0;
		wt(3);
		chk("irq_ret", {irq_o, irq_id, irq_level}, {1'b1, 4'd7, 3'd5});
		// ==========================================================
		// encoder2 request
		apb(1, OFS_FLAG0, 0);
		apb(1, OFS_TRAP, 0);
		apb(1, OFS_PRI18, 16'h7000);
		apb(1, OFS_ENC2, 16'h0002);
		enc2_req <= 1;
		wt(1);
		enc2_req <= 0;
		wt(3);
		chk("irq_enc2", {irq_o, irq_id, irq_level}, {1'b1, 4'd15, 3'd7});
		// ==========================================================
		// request and software clear on one edge: set wins
		fork
			apb(1, OFS_FLAG0, 0);
			begin
				wt(1);
				irq_req <= 15'h0001;
				wt(1);
				irq_req <= 0;
			end
		join
		apb(0, OFS_FLAG0, 0);
		chk("flag_race", rd, 32'h0000_0001);
		// ==========================================================
		// reset in mid-run
		rst <= 1;
		wt(2);
		rst <= 0;
		wt(1);
		chk("irq_rst", irq_o, 0);
		apb(0, OFS_PRI18, 0);
		chk("pri18_rst", rd, 32'h0000_4040);
		final_report();
	end
endmodule : testbench
